// *** rtl/hbpc_ctrl.sv ***
// Purpose: host-side controller driving a three half-bridge power stage
// Assumes: shutdown and warning flags are synchronous to mclk
// Notes: software programs pwm and recovery through AHB-Lite registers
//
// Implementation choices: the register offsets and the AHB-Lite slave port.
`timescale 1ns/10ps
module hbpc_ctrl #(
   parameter int GUARD_CYC = hbpc_pkg::GUARD_S * 100000000
) (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   input wire logic shutdown_flag_n,
   input wire logic overtemp_warning_n,
   output hbpc_pkg::hbpc_drive_t bridge_pins
);
   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   typedef struct packed {
      logic ready; // bus ready, always high
      logic resp; // bus response, always okay
      logic [31:0] rdata; // registered read data
      logic bus_wr; // write data phase pending
      logic [7:0] bus_addr; // captured address
      logic run; // pwm running
      logic latch; // software asks for latching mode
      logic [2:0] bridge_en; // bridges released from reset
      logic [15:0] period; // pwm period in cycles
      logic [2:0][15:0] duty; // high time per bridge
      logic [15:0] per_sh; // period in use this cycle
      logic [2:0][15:0] duty_sh; // clamped duty in use
      logic [15:0] cnt; // position in the period
      logic fault_q; // registered shutdown flag
      logic otw_q; // registered warning flag
      logic fault_seen; // sticky shutdown seen
      logic warn_seen; // sticky warning seen
      logic [hbpc_pkg::GUARD_W-1:0] guard; // cycles since shutdown onset
      hbpc_pkg::hbpc_rcv_t rst_st; // recovery sequencer
      logic recov_req; // recovery requested
      logic [7:0] low_tmr; // reset pulse timer
      hbpc_pkg::hbpc_drive_t drv; // pins toward the stage
      logic [15:0] low_run; // cycles drive A has stayed low, saturating
   } hbpc_state_t;

   hbpc_state_t s_ff; // registered state
   hbpc_state_t nxt_s; // next state

   localparam logic [hbpc_pkg::GUARD_W-1:0] GUARD_LIM = hbpc_pkg::GUARD_W'(GUARD_CYC);

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   // clamp so the low side always gets its minimum pulse
   function automatic logic [15:0] clamp_duty(input logic [15:0] d, input logic [15:0] p);
      logic [15:0] top;
      top = p - hbpc_pkg::MIN_LOW_CYC;
      if (p <= hbpc_pkg::MIN_LOW_CYC)
      begin
         return 16'h0000;
      end
      else if (d > top)
      begin
         return top;
      end
      return d;
   endfunction

   logic guard_done; // guard time since last shutdown has passed
   logic wrap; // last cycle of the period
   logic hold_low; // an enabled bridge has zero duty while running
   logic [1:0] cond; // decoded flag pair
   assign guard_done = (s_ff.guard >= GUARD_LIM);
   assign wrap = ((s_ff.cnt + 16'h0001) >= s_ff.per_sh);
   always_comb
   begin
      hold_low = 1'b0;
      for (int i = 0; i < hbpc_pkg::NUM_BRIDGES; i++)
      begin
         if (s_ff.bridge_en[i] && s_ff.duty[i] == 16'h0000)
         begin
            hold_low = s_ff.run;
         end
      end
   end
   // 00 normal, 01 warning only, 10 shutdown only, 11 both
   assign cond = {~s_ff.fault_q, ~s_ff.otw_q};

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb
   begin
      nxt_s = s_ff;
      nxt_s.ready = 1'b1;
      nxt_s.resp = 1'b0;
      nxt_s.bus_wr = 1'b0;
      nxt_s.fault_q = shutdown_flag_n;
      nxt_s.otw_q = overtemp_warning_n;
      // address phase: capture, and prepare read data now
      if (hsel && htrans[1] && hready)
      begin
         nxt_s.bus_wr = hwrite;
         nxt_s.bus_addr = haddr[7:0];
         if (!hwrite)
         begin
            unique case (haddr[7:0])
               hbpc_pkg::REG_CTRL:
               begin
                  nxt_s.rdata = {26'h0000000, 1'b0, s_ff.bridge_en, s_ff.latch, s_ff.run};
               end
               hbpc_pkg::REG_PERIOD: nxt_s.rdata = {16'h0000, s_ff.period};
               hbpc_pkg::REG_DUTY_A: nxt_s.rdata = {16'h0000, s_ff.duty[0]};
               hbpc_pkg::REG_DUTY_B: nxt_s.rdata = {16'h0000, s_ff.duty[1]};
               hbpc_pkg::REG_DUTY_C: nxt_s.rdata = {16'h0000, s_ff.duty[2]};
               hbpc_pkg::REG_STATUS:
               begin
                  nxt_s.rdata = {24'h000000, cond, guard_done,
                     (s_ff.rst_st != hbpc_pkg::RCV_IDLE), s_ff.warn_seen, s_ff.fault_seen,
                     s_ff.otw_q, s_ff.fault_q};
               end
               default: nxt_s.rdata = 32'h00000000; // unmapped reads zero
            endcase
         end
      end
      // guard timer restarts at each shutdown onset
      if (!shutdown_flag_n && s_ff.fault_q)
      begin
         nxt_s.guard = '0;
      end
      else if (!guard_done)
      begin
         nxt_s.guard = s_ff.guard + 1'b1;
      end
      // recovery sequencer
      unique case (s_ff.rst_st)
         hbpc_pkg::RCV_IDLE:
         begin
            if (s_ff.recov_req)
            begin
               nxt_s.recov_req = 1'b0;
               nxt_s.rst_st = hbpc_pkg::RCV_GUARD;
            end
         end
         hbpc_pkg::RCV_GUARD:
         begin
            // never reset the stage too soon after a shutdown
            if (guard_done)
            begin
               nxt_s.rst_st = hbpc_pkg::RCV_LOW;
               nxt_s.low_tmr = 8'h00;
            end
         end
         hbpc_pkg::RCV_LOW:
         begin
            nxt_s.low_tmr = s_ff.low_tmr + 8'h01;
            if (s_ff.low_tmr == hbpc_pkg::RST_LOW_CYC - 8'h01)
            begin
               nxt_s.rst_st = hbpc_pkg::RCV_IDLE;
            end
         end
         default: nxt_s.rst_st = hbpc_pkg::RCV_IDLE; // illegal code recovers
      endcase
      // data phase: apply the write
      if (s_ff.bus_wr)
      begin
         unique case (s_ff.bus_addr)
            hbpc_pkg::REG_CTRL:
            begin
               nxt_s.run = hwdata[hbpc_pkg::CTRL_RUN];
               nxt_s.latch = hwdata[hbpc_pkg::CTRL_LATCH];
               nxt_s.bridge_en = hwdata[hbpc_pkg::CTRL_EN_LSB +: 3];
               if (hwdata[hbpc_pkg::CTRL_RECOVER])
               begin
                  nxt_s.recov_req = 1'b1;
               end
            end
            hbpc_pkg::REG_PERIOD: nxt_s.period = hwdata[15:0];
            hbpc_pkg::REG_DUTY_A: nxt_s.duty[0] = hwdata[15:0];
            hbpc_pkg::REG_DUTY_B: nxt_s.duty[1] = hwdata[15:0];
            hbpc_pkg::REG_DUTY_C: nxt_s.duty[2] = hwdata[15:0];
            hbpc_pkg::REG_STATUS:
            begin
               // write one to clear, overridden by a set below
               if (hwdata[hbpc_pkg::ST_FAULT_SEEN])
               begin
                  nxt_s.fault_seen = 1'b0;
               end
               if (hwdata[hbpc_pkg::ST_WARN_SEEN])
               begin
                  nxt_s.warn_seen = 1'b0;
               end
            end
            default: nxt_s.run = s_ff.run; // unmapped writes ignored
         endcase
      end
      // sticky events win over a clear in the same cycle
      if (!shutdown_flag_n)
      begin
         nxt_s.fault_seen = 1'b1;
      end
      if (!overtemp_warning_n)
      begin
         nxt_s.warn_seen = 1'b1;
      end
      // pwm: one input per bridge, the stage drives it complementary
      if (!s_ff.run)
      begin
         nxt_s.cnt = 16'h0000;
         nxt_s.per_sh = 16'h0000; // forces a reload at start
         nxt_s.drv.drive = 3'b000;
      end
      else if (wrap)
      begin
         nxt_s.cnt = 16'h0000;
         nxt_s.per_sh = s_ff.period;
         for (int i = 0; i < hbpc_pkg::NUM_BRIDGES; i++)
         begin
            nxt_s.duty_sh[i] = clamp_duty(s_ff.duty[i], s_ff.period);
            nxt_s.drv.drive[i] = (clamp_duty(s_ff.duty[i], s_ff.period) != 16'h0000);
         end
      end
      else
      begin
         nxt_s.cnt = s_ff.cnt + 16'h0001;
         for (int i = 0; i < hbpc_pkg::NUM_BRIDGES; i++)
         begin
            nxt_s.drv.drive[i] = ((s_ff.cnt + 16'h0001) < s_ff.duty_sh[i]);
         end
      end
      // resets: low to park a bridge, pulsed together for recovery
      for (int i = 0; i < hbpc_pkg::NUM_BRIDGES; i++)
      begin
         nxt_s.drv.reset_n[i] = s_ff.run && s_ff.bridge_en[i]
            && (s_ff.rst_st != hbpc_pkg::RCV_LOW);
      end
      // low stretch length, saturating so a long stop never wraps to a short count
      nxt_s.low_run = s_ff.drv.drive[0] ? 16'h0000 : s_ff.low_run + 16'(s_ff.low_run != '1);
      // a bridge at zero duty must not get stuck hi-z under cycle limiting
      nxt_s.drv.protection_mode_select = s_ff.latch || hold_low;
   end

   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         s_ff <= '0;
         s_ff.ready <= 1'b1;
         s_ff.fault_q <= 1'b1;
         s_ff.otw_q <= 1'b1;
         s_ff.guard <= '1; // no shutdown yet, guard already passed
         s_ff.rst_st <= hbpc_pkg::RCV_IDLE;
      end
      else
      begin
         s_ff <= nxt_s;
      end
   end

   assign hreadyout = s_ff.ready;
   assign hresp = s_ff.resp;
   assign hrdata = s_ff.rdata;
   assign bridge_pins = s_ff.drv;

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   a_bus_okay: assert property (@(posedge mclk) disable iff (!rst_n)
      hreadyout && !hresp)
      else $error("bus answer not ready okay");
   a_mode_select: assert property (@(posedge mclk) disable iff (!rst_n)
      (!s_ff.latch && !hold_low) |=> !bridge_pins.protection_mode_select)
      else $error("latching mode selected without cause");
   a_hold_latch: assert property (@(posedge mclk) disable iff (!rst_n)
      hold_low |=> bridge_pins.protection_mode_select)
      else $error("held-low bridge left in cycle limiting mode");
   a_min_low: assert property (@(posedge mclk) disable iff (!rst_n || !s_ff.run)
      $rose(bridge_pins.drive[0]) |-> s_ff.low_run >= hbpc_pkg::MIN_LOW_CYC)
      else $error("low-side pulse shorter than minimum");
   a_period_toggle: assert property (@(posedge mclk) disable iff (!rst_n)
      (s_ff.run && wrap && clamp_duty(s_ff.duty[1], s_ff.period) != 16'h0000)
      |=> bridge_pins.drive[1])
      else $error("drive did not rise at period start");
   a_stop_low: assert property (@(posedge mclk) disable iff (!rst_n)
      !s_ff.run |=> bridge_pins.drive == 3'b000 && bridge_pins.reset_n == 3'b000)
      else $error("stopped controller still drives");
   a_reset_pulse: assert property (@(posedge mclk) disable iff (!rst_n)
      $rose(s_ff.rst_st == hbpc_pkg::RCV_LOW) |=> (bridge_pins.reset_n == 3'b000) [*8])
      else $error("recovery reset pulse too short");
   a_guard_wait: assert property (@(posedge mclk) disable iff (!rst_n)
      $rose(s_ff.rst_st == hbpc_pkg::RCV_LOW) |-> $past(guard_done))
      else $error("recovery reset issued inside guard time");
   a_reset_release: assert property (@(posedge mclk) disable iff (!rst_n)
      ($fell(s_ff.rst_st == hbpc_pkg::RCV_LOW) && s_ff.run)
      |=> bridge_pins.reset_n == $past(s_ff.bridge_en))
      else $error("resets not released after recovery pulse");
   a_fault_sticky: assert property (@(posedge mclk) disable iff (!rst_n)
      !shutdown_flag_n |=> s_ff.fault_seen)
      else $error("shutdown flag not recorded");
endmodule

// *** rtl/hbpc_pkg.sv ***
// Purpose: shared constants and types of the half-bridge protection controller
// Assumes: 100 MHz mclk, AHB-Lite register port with 32-bit data
// Notes: register offsets are byte addresses of aligned words
package hbpc_pkg;
   // ----------------------------------------------------------------
   // clock and timing
   // ----------------------------------------------------------------
   localparam int CLK_NS = 10; // mclk period
   localparam int MIN_LOW_NS = 100; // least low-side pulse each cycle
   localparam logic [15:0] MIN_LOW_CYC = 16'((MIN_LOW_NS + CLK_NS - 1) / CLK_NS);
   localparam int RST_LOW_NS = 1000; // low time of a recovery reset pulse
   localparam logic [7:0] RST_LOW_CYC = 8'((RST_LOW_NS + CLK_NS - 1) / CLK_NS);
   localparam int GUARD_S = 1; // wait after a shutdown before recovery
   localparam int GUARD_W = 27; // width of the guard counter
   // ----------------------------------------------------------------
   // register map
   // ----------------------------------------------------------------
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_PERIOD = 8'h04;
   localparam logic [7:0] REG_DUTY_A = 8'h08;
   localparam logic [7:0] REG_DUTY_B = 8'h0C;
   localparam logic [7:0] REG_DUTY_C = 8'h10;
   localparam logic [7:0] REG_STATUS = 8'h14;
   // control fields
   localparam int CTRL_RUN = 0;
   localparam int CTRL_LATCH = 1;
   localparam int CTRL_EN_LSB = 2;
   localparam int CTRL_RECOVER = 5;
   // status fields
   localparam int ST_FAULT_N = 0;
   localparam int ST_OTW_N = 1;
   localparam int ST_FAULT_SEEN = 2;
   localparam int ST_WARN_SEEN = 3;
   localparam int ST_BUSY = 4;
   localparam int ST_GUARD_DONE = 5;
   localparam int ST_COND_LSB = 6;
   localparam int NUM_BRIDGES = 3;
   // ----------------------------------------------------------------
   // types
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      RCV_IDLE = 2'b00,
      RCV_GUARD = 2'b01,
      RCV_LOW = 2'b10
   } hbpc_rcv_t;
   // pins toward the power stage
   typedef struct packed {
      logic protection_mode_select; // 1 selects latching shutdown
      logic [2:0] reset_n; // per bridge, low forces hi-z
      logic [2:0] drive; // per bridge drive input
   } hbpc_drive_t;
endpackage

// *** sim/hbpc_stage_model.sv ***
// Purpose: behavioural three half-bridge power stage seen by the controller
// Assumes: fault stimuli come from the bench on mclk
// Notes: flags are registered, so they move one edge after uv or warm, two edges after a latched cause
`timescale 1ns/10ps
module hbpc_stage_model (
   input wire logic mclk,
   input wire logic rst_n,
   input wire hbpc_pkg::hbpc_drive_t pins,
   input wire logic [2:0] oc,
   input wire logic [2:0] sc,
   input wire logic warm,
   input wire logic hot,
   input wire logic uv,
   output logic shutdown_flag_n,
   output logic overtemp_warning_n,
   output logic [2:0] hiz
);
   // ----------------------------------------------------------------
   // fault latches
   // ----------------------------------------------------------------
   hbpc_pkg::hbpc_drive_t p_ff; // registered pins
   logic [2:0] blk_ff; // cycle limit block per bridge
   logic [2:0] sc_ff; // short latch per bridge
   logic [2:0] seen_ff; // reset rises seen while latched
   logic ocl_ff; // latching-mode trip
   logic hot_ff; // thermal latch
   logic [2:0] rise;
   logic all_up;
   assign rise = pins.reset_n & ~p_ff.reset_n;
   assign all_up = &(seen_ff | rise);
   // outputs float on a low reset, a cycle-limit block or any shutdown cause, a short floating only its own bridge
   assign hiz = ~pins.reset_n | blk_ff | sc_ff | {3{ocl_ff | hot_ff | uv}};
   // power-on reset keeps every latch clear
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         p_ff <= '0;
         blk_ff <= 3'b000;
         sc_ff <= 3'b000;
         seen_ff <= 3'b000;
         ocl_ff <= 1'b0;
         hot_ff <= 1'b0;
         shutdown_flag_n <= 1'b1;
         overtemp_warning_n <= 1'b1;
      end
      else
      begin
         p_ff <= pins;
         // a drive toggle starts the next cycle and ends the block
         blk_ff <= (blk_ff & ~(pins.drive ^ p_ff.drive))
            | (oc & {3{~pins.protection_mode_select}});
         sc_ff <= (sc_ff & ~rise) | sc;
         seen_ff <= (ocl_ff | hot_ff) ? (seen_ff | rise) : 3'b000;
         ocl_ff <= (ocl_ff & ~all_up) | (|oc & pins.protection_mode_select);
         hot_ff <= (hot_ff & ~all_up) | hot;
         shutdown_flag_n <= ~(ocl_ff | hot_ff | (|sc_ff) | uv);
         overtemp_warning_n <= ~warm;
      end
   end
endmodule

// *** sim/test_half_bridge_protection_control.sv ***
// Purpose: self-checking bench for the protection controller
// Assumes: stage model answers faults, guard shortened to 50 cycles
// Notes: expectations come from counts kept here and hbpc_pkg constants, never from design state
`timescale 1ns/10ps
module test_half_bridge_protection_control;
   // ----------------------------------------------------------------
   // signals and instances
   // ----------------------------------------------------------------
   logic mclk, rst_n, hsel, hwrite, hreadyout, hresp;
   logic [31:0] haddr, hwdata, hrdata, lfsr_ff, rd;
   logic [1:0] htrans;
   logic [2:0] hsize, oc, sc, hiz;
   logic flag_n, warn_n, warm, hot, uv;
   hbpc_pkg::hbpc_drive_t pins;
   int error_cnt, compares, cyc, hi, lo, p, d, t0;
   logic [31:0] base [3] = '{32'h1F, 32'h1D, 32'h1D}; // ctrl per fault kind
   hbpc_ctrl #(.GUARD_CYC(50)) u_hbpc_ctrl (.mclk(mclk), .rst_n(rst_n), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
      .shutdown_flag_n(flag_n), .overtemp_warning_n(warn_n), .bridge_pins(pins));
   hbpc_stage_model u_hbpc_stage_model (.mclk(mclk), .rst_n(rst_n), .pins(pins),
      .oc(oc), .sc(sc), .warm(warm), .hot(hot), .uv(uv), .shutdown_flag_n(flag_n),
      .overtemp_warning_n(warn_n), .hiz(hiz));
   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task automatic test_done();
   begin
      if (error_cnt == 0 && compares > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   end
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
   begin
      compares++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   end
   endtask
   // one single transfer; entered just after a rising edge
   task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
   begin
      hsel <= 1'b1;
      htrans <= 2'b10;
      hwrite <= wr;
      haddr <= {24'h000000, a};
      @(posedge mclk);
      while (hreadyout !== 1'b1) @(posedge mclk);
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= wd;
      @(posedge mclk);
      while (hreadyout !== 1'b1) @(posedge mclk);
      rd = hrdata;
   end
   endtask
   task automatic idle(input int n);
      repeat (n) @(posedge mclk);
   endtask
   // cycles high then low of one drive period
   task automatic meas(input int b);
   begin
      hi = 0;
      lo = 0;
      while (pins.drive[b] !== 1'b0) @(posedge mclk);
      while (pins.drive[b] !== 1'b1) @(posedge mclk);
      while (pins.drive[b] === 1'b1)
      begin
         @(posedge mclk);
         hi++;
      end
      while (pins.drive[b] === 1'b0)
      begin
         @(posedge mclk);
         lo++;
      end
   end
   endtask
   // ----------------------------------------------------------------
   // clock, timeout and sequence
   // ----------------------------------------------------------------
   initial
   begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end
   // a hang is cut short and counted
   always @(posedge mclk)
   begin
      cyc <= cyc + 1;
      if (cyc == 40000)
      begin
         error_cnt++;
         test_done();
      end
   end
   initial
   begin
      {rst_n, hsel, hwrite, warm, hot, uv} = 6'b000000;
      {haddr, hwdata, htrans, oc, sc} = '0;
      hsize = 3'b010;
      lfsr_ff = 32'h33BC;
      error_cnt = 0;
      compares = 0;
      cyc = 0;
      repeat (8) @(posedge mclk);
      rst_n <= 1'b1;
      @(posedge mclk);
      chk({25'h0, pins}, 32'h0);
      ahb(0, hbpc_pkg::REG_STATUS, 32'h0);
      chk(rd, 32'h23);
      ahb(1, 8'h18, 32'hFFFFFFFF);
      ahb(0, 8'h18, 32'h0);
      chk(rd, 32'h0);
      // warning alone, then sticky clear
      warm <= 1'b1;
      idle(3);
      ahb(0, hbpc_pkg::REG_STATUS, 32'h0);
      chk(rd, 32'h69);
      warm <= 1'b0;
      idle(3);
      ahb(1, hbpc_pkg::REG_STATUS, 32'h0C);
      ahb(0, hbpc_pkg::REG_STATUS, 32'h0);
      chk(rd, 32'h23);
      // random period and duty on bridge A alone
      lfsr_ff = lfsr(lfsr_ff);
      p = 20 + int'(lfsr_ff % 20);
      lfsr_ff = lfsr(lfsr_ff);
      d = 1 + int'(lfsr_ff % (p - 10));
      ahb(1, hbpc_pkg::REG_PERIOD, p);
      ahb(1, hbpc_pkg::REG_DUTY_A, d);
      ahb(1, hbpc_pkg::REG_CTRL, 32'h05);
      idle(2 * p);
      meas(0);
      chk(hi, d);
      chk(lo, p - d);
      chk(pins.reset_n, 3'b001);
      chk(pins.protection_mode_select, 1'b0);
      // full duty is clamped to keep the low pulse
      ahb(1, hbpc_pkg::REG_DUTY_A, p);
      idle(3 * p);
      meas(0);
      chk(hi, p - int'(hbpc_pkg::MIN_LOW_CYC));
      chk(lo, hbpc_pkg::MIN_LOW_CYC);
      ahb(1, hbpc_pkg::REG_CTRL, 32'h07);
      idle(3);
      chk(pins.protection_mode_select, 1'b1);
      ahb(1, hbpc_pkg::REG_CTRL, 32'h0D);
      idle(2 * p);
      chk(pins.protection_mode_select, 1'b1);
      ahb(1, hbpc_pkg::REG_DUTY_B, d);
      ahb(1, hbpc_pkg::REG_DUTY_C, d);
      ahb(1, hbpc_pkg::REG_CTRL, 32'h1D);
      idle(3 * p);
      chk(pins.protection_mode_select, 1'b0);
      chk(pins.reset_n, 3'b111);
      // a limited trip raises no shutdown
      oc <= 3'b001;
      @(posedge mclk);
      oc <= 3'b000;
      idle(3);
      ahb(0, hbpc_pkg::REG_STATUS, 32'h0);
      chk(rd, 32'h23);
      // latching trip, thermal trip, short: guarded recovery
      for (int k = 0; k < 3; k++)
      begin
         ahb(1, hbpc_pkg::REG_CTRL, base[k]);
         idle(3);
         oc <= (k == 0) ? 3'b001 : 3'b000;
         hot <= (k == 1);
         sc <= (k == 2) ? 3'b010 : 3'b000;
         @(posedge mclk);
         {oc, sc, hot} <= '0;
         while (flag_n !== 1'b0) @(posedge mclk);
         t0 = cyc;
         idle(2);
         ahb(0, hbpc_pkg::REG_STATUS, 32'h0);
         chk(rd, 32'h86);
         ahb(1, hbpc_pkg::REG_CTRL, base[k] | 32'h20);
         while (pins.reset_n !== 3'b000) @(posedge mclk);
         chk(cyc - t0 >= 50, 1);
         lo = 0;
         while (pins.reset_n === 3'b000)
         begin
            @(posedge mclk);
            lo++;
         end
         chk(lo, hbpc_pkg::RST_LOW_CYC);
         idle(4);
         chk(flag_n, 1'b1);
         ahb(1, hbpc_pkg::REG_STATUS, 32'h0C);
      end
      // undervoltage recovers without any reset
      uv <= 1'b1;
      idle(3);
      chk(hiz, 3'b111);
      ahb(0, hbpc_pkg::REG_STATUS, 32'h0);
      chk(rd & 32'h81, 32'h80);
      uv <= 1'b0;
      idle(3);
      ahb(0, hbpc_pkg::REG_STATUS, 32'h0);
      chk(rd & 32'h81, 32'h01);
      test_done();
   end
endmodule
